// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the enhanced flow control block
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        thr_empty, tsr_empty, tx_load, tx_push, tx_pop, rx_push, rx_pop;
  logic        rx_valid, ctrl_ready, cts_n, dsr_n, ir_rx, rts_n, dtr_n, ir_rx_data;
  logic        tx_halt, tx_int, tx_trig_int, rx_trig_int, rx_store, stop_det;
  logic        special_det, ctrl_valid, stall, ir_level, ce;
  logic [7:0]  rx_char, ctrl_char, got_char;
  logic [1:0]  stop_req;
  int          got_n, rxc_m, txc_m, n_st, n_sd, n_sp;
  int          seed = 56101;
  int          num_errors, samples_checked;
  int          hys_tbl[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

  uefc_top i_uefc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .thr_empty(thr_empty),
    .tsr_empty(tsr_empty), .tx_load(tx_load), .tx_push(tx_push), .tx_pop(tx_pop),
    .rx_push(rx_push), .rx_pop(rx_pop), .rx_valid(rx_valid), .rx_char(rx_char),
    .ctrl_ready(ctrl_ready), .cts_n(cts_n), .dsr_n(dsr_n), .ir_rx(ir_rx),
    .rts_n(rts_n), .dtr_n(dtr_n), .ir_rx_data(ir_rx_data), .tx_halt(tx_halt),
    .tx_int(tx_int), .tx_trig_int(tx_trig_int), .rx_trig_int(rx_trig_int),
    .rx_store(rx_store), .stop_det(stop_det), .special_det(special_det),
    .ctrl_char(ctrl_char), .ctrl_valid(ctrl_valid));

  uefc_remote i_uefc_remote (.pclk(pclk), .presetn(presetn), .ctrl_valid(ctrl_valid),
    .ctrl_char(ctrl_char), .stall(stall), .stop_req(stop_req), .ir_level(ir_level),
    .ctrl_ready(ctrl_ready), .cts_n(cts_n), .dsr_n(dsr_n), .ir_rx(ir_rx),
    .got_char(got_char), .got_n(got_n));

  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Remote stalls at random, mixing prompt and slow accepts
  always @(posedge pclk) stall <= ($random(seed) & 3) != 0;

  // Pulses stand one cycle, so mid-cycle sampling sees each exactly once
  always @(negedge pclk) begin
    if (rx_store === 1'b1) n_st++;
    if (stop_det === 1'b1) n_sd++;
    if (special_det === 1'b1) n_sp++;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [31:0] x, input logic xe);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // Answer taken at the completing edge, request released by the same edge
    if (!w) chk("prdata", x, prdata);
    chk("pslverr", {31'h00000000, xe}, {31'h00000000, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= 32'hFFFFFFFF;
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // k: 0 tx push, 1 tx pop, 2 rx push, 3 rx pop; n back-to-back pulses
  task automatic pulse(input int k, input int n);
    @(posedge pclk);
    {rx_pop, rx_push, tx_pop, tx_push} <= 4'h1 << k;
    repeat (n) @(posedge pclk);
    {rx_pop, rx_push, tx_pop, tx_push} <= 4'h0;
    case (k)
      0: txc_m += n;
      1: txc_m -= n;
      2: rxc_m += n;
      default: rxc_m -= n;
    endcase
  endtask

  task automatic rxch(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic drv(input logic [1:0] s, input logic ld, input logic te);
    @(posedge pclk);
    stop_req  <= s;
    tx_load   <= ld;
    tsr_empty <= te;
  endtask

  // Wait, bounded, for the remote to take one more flow character
  task automatic wait_got(input int k, input logic [7:0] x);
    int n;
    n = 0;
    while (got_n <= k && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("got_n", k + 1, got_n);
    chk("got_char", x, got_char);
    if (got_n <= k) give_verdict();
  endtask

  initial begin
    logic [1:0] b;
    logic [7:0] c;
    int k;
    {psel, penable, pwrite, tx_load, tx_push, tx_pop, rx_push, rx_pop, rx_valid} = '0;
    {paddr, pwdata, rx_char, stop_req, ir_level, stall} = '0;
    thr_empty = 1'b1;
    tsr_empty = 1'b0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, refused accesses and the read-only counter
    apb(0, 12'h000, 8'h00, 32'h0, 0);
    apb(0, 12'h004, 8'h00, 32'h0, 0);
    apb(1, 12'h100, 8'hFF, 32'h0, 1);
    apb(1, 12'h010, 8'h05, 32'h0, 1);
    apb(0, 12'h010, 8'h00, 32'h0, 0);
    chk("tx_int", 1, tx_int);
    @(posedge pclk);
    thr_empty <= 1'b0;
    wt(3);
    chk("tx_int", 0, tx_int);
    @(posedge pclk);
    thr_empty <= 1'b1;
    // Direction control: interrupt source moves to the shift register
    apb(1, 12'h000, 8'h20, 32'h0, 0);
    wt(3);
    chk("tx_int", 0, tx_int);
    drv(2'b00, 1, 0);
    drv(2'b00, 0, 0);
    wt(3);
    chk("rts_n", 1, rts_n);
    drv(2'b00, 0, 1);
    wt(3);
    chk("rts_n", 0, rts_n);
    chk("tx_int", 1, tx_int);
    // IR polarity with random input level and random polarity
    for (int i = 0; i < 4; i++) begin
      b = $random(seed);
      apb(1, 12'h000, {3'h0, b[1], 4'h0}, 32'h0, 0);
      ir_level <= b[0];
      wt(5);
      chk("ir_rx_data", b[0] ^ b[1], ir_rx_data);
    end
    // Gated select bit latches; auto clear flow watches the chosen pin
    apb(1, 12'h004, 8'h10, 32'h0, 0);
    apb(1, 12'h028, 8'h04, 32'h0, 0);
    apb(1, 12'h004, 8'h80, 32'h0, 0);
    apb(1, 12'h028, 8'h00, 32'h0, 0);
    apb(0, 12'h028, 8'h00, 32'h4, 0);
    drv(2'b01, 0, 1);
    wt(5);
    chk("tx_halt", 0, tx_halt);
    drv(2'b10, 0, 1);
    wt(5);
    chk("tx_halt", 1, tx_halt);
    drv(2'b00, 0, 1);
    apb(1, 12'h004, 8'h10, 32'h0, 0);
    apb(1, 12'h028, 8'h02, 32'h0, 0);
    apb(1, 12'h004, 8'h00, 32'h0, 0);
    wt(3);
    chk("rts_n", 0, rts_n);
    chk("dtr_n", 1, dtr_n);
    // Special character, then second-pair compare suppressing the store
    c = $random(seed);
    c[7] = 1'b1;
    apb(1, 12'h01C, c, 32'h0, 0);
    apb(0, 12'h01C, 8'h00, 32'h0, 0);
    apb(1, 12'h004, 8'h20, 32'h0, 0);
    rxch(c);
    rxch(c ^ 8'h01);
    apb(1, 12'h004, 8'h00, 32'h0, 0);
    apb(1, 12'h004, 8'h21, 32'h0, 0);
    rxch(c);
    wt(3);
    chk("store count", 2, n_st);
    chk("special count", 2, n_sp);
    chk("stop count", 1, n_sd);
    chk("tx_halt", 1, tx_halt);
    apb(1, 12'h004, 8'h00, 32'h0, 0);
    // Table D hysteresis around trigger 20 with code 5, first pair sent
    apb(1, 12'h014, 8'h14, 32'h0, 0);
    apb(1, 12'h018, 8'hA5, 32'h0, 0);
    apb(1, 12'h020, 8'h5A, 32'h0, 0);
    apb(1, 12'h000, 8'hC5, 32'h0, 0);
    apb(1, 12'h004, 8'h48, 32'h0, 0);
    pulse(2, 20 + hys_tbl[5] - 1);
    wt(4);
    chk("rx_trig_int", 1, rx_trig_int);
    chk("rts_n", 0, rts_n);
    k = got_n;
    pulse(2, 1);
    wt(4);
    chk("rts_n", 1, rts_n);
    wait_got(k, 8'hA5);
    pulse(3, rxc_m - (20 - hys_tbl[5]));
    wt(4);
    chk("rts_n", 1, rts_n);
    k = got_n;
    pulse(3, 1);
    wt(4);
    chk("rts_n", 0, rts_n);
    wait_got(k, 8'h5A);
    apb(0, 12'h010, 8'h00, rxc_m, 0);
    // Transmit level counter and trigger
    apb(1, 12'h00C, 8'h04, 32'h0, 0);
    pulse(0, 5);
    pulse(1, 2);
    apb(0, 12'h008, 8'h00, txc_m, 0);
    chk("tx_trig_int", txc_m < 4, tx_trig_int);
    pulse(0, 1);
    wt(3);
    chk("tx_trig_int", txc_m < 4, tx_trig_int);
    // Clock enable low freezes the fill counter while pushes arrive
    @(posedge pclk);
    ce      <= 1'b0;
    tx_push <= 1'b1;
    repeat (3) @(posedge pclk);
    ce      <= 1'b1;
    tx_push <= 1'b0;
    apb(0, 12'h008, 8'h00, txc_m, 0);
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ==== bench/uefc_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
// Remote serial device: takes flow characters, drives handshake and IR pins
module uefc_remote (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ctrl_valid,
  input  wire logic [7:0] ctrl_char,
  input  wire logic       stall,
  input  wire logic [1:0] stop_req,
  input  wire logic       ir_level,
  output var  logic       ctrl_ready,
  output wire logic       cts_n,
  output wire logic       dsr_n,
  output wire logic       ir_rx,
  output var  logic [7:0] got_char,
  output var  int         got_n
);
  // High on a handshake pin asks the local transmitter to stop
  assign cts_n = stop_req[0];
  assign dsr_n = stop_req[1];
  assign ir_rx = ir_level;

  // Single-cycle accepts, so a stalling remote holds off each character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ready <= 1'b0;
      got_char   <= 8'h00;
      got_n      <= 0;
    end else begin
      ctrl_ready <= ctrl_valid && !stall && !ctrl_ready;
      if (ctrl_valid && ctrl_ready) begin
        got_char <= ctrl_char;
        got_n    <= got_n + 1;
      end
    end
  end
endmodule // uefc_remote
`default_nettype wire

// ==== inc/uefc_consts.svh ====
`ifndef UEFC_CONSTS_SVH
`define UEFC_CONSTS_SVH
// Register byte offsets
`define UEFC_OFF_FEATURE_CONTROL_REG    12'h000
`define UEFC_OFF_EFR     12'h004
`define UEFC_OFF_TX_FIFO_LEVEL_COUNT   12'h008
`define UEFC_OFF_TX_FIFO_TRIGGER_LEVEL   12'h00C
`define UEFC_OFF_RX_FIFO_LEVEL_COUNT   12'h010
`define UEFC_OFF_RX_FIFO_TRIGGER_LEVEL   12'h014
`define UEFC_OFF_STOP1   12'h018
`define UEFC_OFF_STOP2   12'h01C
`define UEFC_OFF_RES1    12'h020
`define UEFC_OFF_RES2    12'h024
`define UEFC_OFF_MCR     12'h028
`define UEFC_OFF_MSRW    12'h02C
`define UEFC_OFF_STAT    12'h030
// Reset values
`define UEFC_RST_BYTE    8'h00
`define UEFC_RST_WORD    32'h0000_0000
// Feature control fields
`define UEFC_FEATURE_CONTROL_REG_TBL_HI 7
`define UEFC_FEATURE_CONTROL_REG_TBL_LO 6
`define UEFC_FEATURE_CONTROL_REG_RS485  5
`define UEFC_FEATURE_CONTROL_REG_IRINV  4
`define UEFC_FEATURE_CONTROL_REG_HYS_HI 3
`define UEFC_TBL_D       2'h3
// Enhanced feature fields
`define UEFC_EFR_ACTS    7
`define UEFC_EFR_ARTS    6
`define UEFC_EFR_SPEC    5
`define UEFC_EFR_ENH     4
`define UEFC_EFR_TX_HI   3
`define UEFC_EFR_TX_LO   2
`define UEFC_EFR_RX_HI   1
`define UEFC_FLOW_NONE   2'h0
`define UEFC_FLOW_P2     2'h1
`define UEFC_FLOW_P1     2'h2
`define UEFC_FLOW_BOTH   2'h3
// Modem control fields and write-gated masks
`define UEFC_MCR_DTR     0
`define UEFC_MCR_RTS     1
`define UEFC_MCR_SEL     2
`define UEFC_MCR_ENH     8'hEC
`define UEFC_MSR_ENH     8'hFC
// Hysteresis character counts, code 15 down to 0, one byte each
`define UEFC_HYS_TABLE   128'h241C140C_34302C28_20181008_08060400
// Trigger step used outside table D hysteresis
`define UEFC_NEXT_STEP   9'h004
`endif

// ==== inc/uefc_pkg.sv ====
package uefc_pkg;
  // Transmit flow character sender
  typedef enum logic [1:0] {
    UEFC_IDLE  = 2'b00,
    UEFC_CHAR1 = 2'b01,
    UEFC_CHAR2 = 2'b10
  } uefc_send_t;
endpackage

// ==== src/uefc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uefc_consts.svh"

module uefc_top #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        thr_empty,
  input  wire logic        tsr_empty,
  input  wire logic        tx_load,
  input  wire logic        tx_push,
  input  wire logic        tx_pop,
  input  wire logic        rx_push,
  input  wire logic        rx_pop,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        ctrl_ready,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ir_rx,
  output var  logic        rts_n,
  output var  logic        dtr_n,
  output var  logic        ir_rx_data,
  output var  logic        tx_halt,
  output var  logic        tx_int,
  output var  logic        tx_trig_int,
  output var  logic        rx_trig_int,
  output var  logic        rx_store,
  output var  logic        stop_det,
  output var  logic        special_det,
  output var  logic [7:0]  ctrl_char,
  output var  logic        ctrl_valid
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255) begin : g_bad_depth
    $error("FIFO_DEPTH must lie in 1..255");
  end

  localparam logic [7:0] DEPTH = 8'(FIFO_DEPTH);

  // Hysteresis count for a code; one packed constant keeps the table in one place
  function automatic logic [7:0] hys_count(input logic [3:0] code);
    logic [127:0] tbl;
    tbl = `UEFC_HYS_TABLE;
    hys_count = tbl[{code, 3'b000} +: 8];
  endfunction

  // Up/down FIFO fill, saturating at both ends
  function automatic logic [7:0] fill_next(input logic [7:0] cnt, input logic up,
                                           input logic dn);
    fill_next = cnt;
    if (up && !dn && cnt < DEPTH) begin
      fill_next = cnt + 8'h01;
    end else if (dn && !up && cnt != 8'h00) begin
      fill_next = cnt - 8'h01;
    end
  endfunction

  // Registers
  logic [7:0]  feature_control_reg_q, efr_q, tx_fifo_level_count_q, tx_fifo_trigger_level_q, rx_fifo_level_count_q, rx_fifo_trigger_level_q;
  logic [7:0]  stop1_q, stop2_q, res1_q, res2_q, mcr_q, msrw_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  // Synchronisers: stage 1 feeds stage 2 only
  logic [2:0]  pin_s1_q, pin_s2_q;
  // Line-side state
  logic        rts_n_q, dtr_n_q, ir_q, halt_q, tx_int_q, tx_trg_int_q, rx_trg_int_q;
  logic        store_q, stop_det_q, special_q, tx_busy_q, rx_full_q, remote_stop_q;
  logic        stop_seen_q, res_seen_q, sent_stop_q, send_stop_q;
  logic [7:0]  ctrl_char_q;
  logic        ctrl_valid_q;
  uefc_pkg::uefc_send_t send_q, send_d;

  // Bus decode
  wire         setup   = psel && !penable && !pready_q;
  wire         wr_fire = psel && penable && pready_q && pwrite;
  wire         s_feature_control_reg  = paddr == `UEFC_OFF_FEATURE_CONTROL_REG;
  wire         s_efr   = paddr == `UEFC_OFF_EFR;
  wire         s_tx_fifo_level_count = paddr == `UEFC_OFF_TX_FIFO_LEVEL_COUNT;
  wire         s_tx_fifo_trigger_level = paddr == `UEFC_OFF_TX_FIFO_TRIGGER_LEVEL;
  wire         s_rx_fifo_level_count = paddr == `UEFC_OFF_RX_FIFO_LEVEL_COUNT;
  wire         s_rx_fifo_trigger_level = paddr == `UEFC_OFF_RX_FIFO_TRIGGER_LEVEL;
  wire         s_stop1 = paddr == `UEFC_OFF_STOP1;
  wire         s_stop2 = paddr == `UEFC_OFF_STOP2;
  wire         s_res1  = paddr == `UEFC_OFF_RES1;
  wire         s_res2  = paddr == `UEFC_OFF_RES2;
  wire         s_mcr   = paddr == `UEFC_OFF_MCR;
  wire         s_msrw  = paddr == `UEFC_OFF_MSRW;
  wire         s_stat  = paddr == `UEFC_OFF_STAT;
  wire         hit     = s_feature_control_reg | s_efr | s_tx_fifo_level_count | s_tx_fifo_trigger_level | s_rx_fifo_level_count | s_rx_fifo_trigger_level |
                         s_stop1 | s_stop2 | s_res1 | s_res2 | s_mcr | s_msrw | s_stat;
  // Counters are read-only; a write there is an error too
  wire         bad     = !hit || (pwrite && (s_tx_fifo_level_count || s_rx_fifo_level_count || s_stat));
  wire [7:0]   wbyte   = pwdata[7:0];
  wire         enh_wr  = efr_q[`UEFC_EFR_ENH];

  // Write-only registers read as zero
  wire [7:0]   stat_v  = {5'h00, remote_stop_q, rx_full_q, tx_busy_q};
  wire [7:0]   rd_byte = s_feature_control_reg  ? feature_control_reg_q  :
                         s_efr   ? efr_q   :
                         s_tx_fifo_level_count ? tx_fifo_level_count_q :
                         s_rx_fifo_level_count ? rx_fifo_level_count_q :
                         s_mcr   ? mcr_q   :
                         s_stat  ? stat_v  : `UEFC_RST_BYTE;

  // Gated merge: masked bits keep their old value unless enabled
  wire [7:0]   mcr_d   = enh_wr ? wbyte :
                         ((mcr_q & `UEFC_MCR_ENH) | (wbyte & ~`UEFC_MCR_ENH));
  wire [7:0]   msrw_d  = enh_wr ? wbyte :
                         ((msrw_q & `UEFC_MSR_ENH) | (wbyte & ~`UEFC_MSR_ENH));

  // Mode fields
  wire [1:0]   tx_mode = efr_q[`UEFC_EFR_TX_HI:`UEFC_EFR_TX_LO];
  wire [1:0]   rx_mode = efr_q[`UEFC_EFR_RX_HI:0];
  wire         sel_dtr = mcr_q[`UEFC_MCR_SEL];
  wire         rs485   = feature_control_reg_q[`UEFC_FEATURE_CONTROL_REG_RS485];
  wire         tbl_d   = feature_control_reg_q[`UEFC_FEATURE_CONTROL_REG_TBL_HI:`UEFC_FEATURE_CONTROL_REG_TBL_LO] == `UEFC_TBL_D;
  wire [3:0]   hys_cd  = feature_control_reg_q[`UEFC_FEATURE_CONTROL_REG_HYS_HI:0];

  // Hardware flow thresholds around the receive trigger
  wire         use_hys = tbl_d && hys_cd != 4'h0;
  wire [8:0]   step    = use_hys ? {1'b0, hys_count(hys_cd)} : `UEFC_NEXT_STEP;
  wire [8:0]   up_raw  = {1'b0, rx_fifo_trigger_level_q} + step;
  wire [8:0]   upper   = (up_raw > {1'b0, DEPTH}) ? {1'b0, DEPTH} : up_raw;
  wire [8:0]   lower   = ({1'b0, rx_fifo_trigger_level_q} > step) ? ({1'b0, rx_fifo_trigger_level_q} - step) : 9'h000;
  wire         at_up   = {1'b0, rx_fifo_level_count_q} >= upper;
  wire         below   = {1'b0, rx_fifo_level_count_q} < lower;

  // Synchronised pins
  wire         cts_s   = pin_s2_q[0];
  wire         dsr_s   = pin_s2_q[1];
  wire         ir_s    = pin_s2_q[2];

  // Receive character compare; sequence mode needs char 1 then char 2
  wire         seq     = rx_mode == `UEFC_FLOW_BOTH &&
                         (tx_mode == `UEFC_FLOW_BOTH || tx_mode == `UEFC_FLOW_NONE);
  wire         m_s1    = rx_char == stop1_q;
  wire         m_s2    = rx_char == stop2_q;
  wire         m_r1    = rx_char == res1_q;
  wire         m_r2    = rx_char == res2_q;
  wire         stop_hit = rx_valid && (seq ? (stop_seen_q && m_s2) :
                          (rx_mode[1] && m_s1) || (rx_mode[0] && m_s2));
  wire         res_hit  = rx_valid && (seq ? (res_seen_q && m_r2) :
                          (rx_mode[1] && m_r1) || (rx_mode[0] && m_r2));
  wire         spec_hit = rx_valid && efr_q[`UEFC_EFR_SPEC] && m_s2;
  // Flow characters are consumed; others, special ones included, go to the FIFO
  wire         store_d  = rx_valid && !stop_hit && !res_hit;

  // Selected handshake outputs; holds because the software bit gates the pin low
  wire         auto_rx  = efr_q[`UEFC_EFR_ARTS];
  wire         rts_sw_n = !mcr_q[`UEFC_MCR_RTS];
  wire         dtr_sw_n = !mcr_q[`UEFC_MCR_DTR];
  wire         tx_busy_d = tx_load ? 1'b1 : ((tsr_empty && thr_empty) ? 1'b0 : tx_busy_q);
  wire         rts_n_d  = rs485 ? tx_busy_d :
                          (auto_rx && !sel_dtr) ? (rts_sw_n || rx_full_q) :
                          rts_sw_n;
  wire         dtr_n_d  = (auto_rx && sel_dtr) ? (dtr_sw_n || rx_full_q) : dtr_sw_n;
  wire         halt_d   = (efr_q[`UEFC_EFR_ACTS] && (sel_dtr ? dsr_s : cts_s)) ||
                          remote_stop_q;
  wire         rx_full_d = at_up ? 1'b1 : (below ? 1'b0 : rx_full_q);

  // Sender: local fill state decides stop or resume
  wire         need_stop = tx_mode != `UEFC_FLOW_NONE && rx_full_q && !sent_stop_q;
  wire         need_res  = tx_mode != `UEFC_FLOW_NONE && !rx_full_q && sent_stop_q;
  wire         take      = ctrl_valid_q && ctrl_ready;
  wire [7:0]   char_p1   = send_stop_q ? stop1_q : res1_q;
  wire [7:0]   char_p2   = send_stop_q ? stop2_q : res2_q;

  always_comb begin
    send_d = send_q;
    case (send_q)
      uefc_pkg::UEFC_IDLE: begin
        if (need_stop || need_res) begin
          send_d = uefc_pkg::UEFC_CHAR1;
        end
      end
      uefc_pkg::UEFC_CHAR1: begin
        if (take) begin
          send_d = (tx_mode == `UEFC_FLOW_BOTH) ? uefc_pkg::UEFC_CHAR2 :
                                                   uefc_pkg::UEFC_IDLE;
        end
      end
      uefc_pkg::UEFC_CHAR2: begin
        if (take) begin
          send_d = uefc_pkg::UEFC_IDLE;
        end
      end
      default: send_d = uefc_pkg::UEFC_IDLE;
    endcase
  end

  // APB slave: one wait-free access phase, answer registered at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `UEFC_RST_WORD;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= setup;
      pslverr_q <= setup && bad;
      if (setup) begin
        prdata_q <= {24'h000000, pwrite ? `UEFC_RST_BYTE : rd_byte};
      end
    end
  end

  // Software-written registers; a write lands only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_control_reg_q  <= `UEFC_RST_BYTE;
      efr_q   <= `UEFC_RST_BYTE;
      tx_fifo_trigger_level_q <= `UEFC_RST_BYTE;
      rx_fifo_trigger_level_q <= `UEFC_RST_BYTE;
      stop1_q <= `UEFC_RST_BYTE;
      stop2_q <= `UEFC_RST_BYTE;
      res1_q  <= `UEFC_RST_BYTE;
      res2_q  <= `UEFC_RST_BYTE;
      mcr_q   <= `UEFC_RST_BYTE;
      msrw_q  <= `UEFC_RST_BYTE;
    end else if (ce && wr_fire) begin
      if (s_feature_control_reg)  feature_control_reg_q  <= wbyte;
      if (s_efr)   efr_q   <= wbyte;
      if (s_tx_fifo_trigger_level) tx_fifo_trigger_level_q <= wbyte;
      if (s_rx_fifo_trigger_level) rx_fifo_trigger_level_q <= wbyte;
      if (s_stop1) stop1_q <= wbyte;
      if (s_stop2) stop2_q <= wbyte;
      if (s_res1)  res1_q  <= wbyte;
      if (s_res2)  res2_q  <= wbyte;
      if (s_mcr)   mcr_q   <= mcr_d;
      if (s_msrw)  msrw_q  <= msrw_d;
    end
  end

  // Fill counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fifo_level_count_q <= `UEFC_RST_BYTE;
      rx_fifo_level_count_q <= `UEFC_RST_BYTE;
    end else if (ce) begin
      tx_fifo_level_count_q <= fill_next(tx_fifo_level_count_q, tx_push, tx_pop);
      rx_fifo_level_count_q <= fill_next(rx_fifo_level_count_q, rx_push, rx_pop);
    end
  end

  // Pin synchronisers, two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h3;
      pin_s2_q <= 3'h3;
    end else if (ce) begin
      pin_s1_q <= {ir_rx, dsr_n, cts_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pins, interrupts and direction state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n_q      <= 1'b1;
      dtr_n_q      <= 1'b1;
      ir_q         <= 1'b0;
      halt_q       <= 1'b0;
      tx_int_q     <= 1'b0;
      tx_trg_int_q <= 1'b0;
      rx_trg_int_q <= 1'b0;
      tx_busy_q    <= 1'b0;
      rx_full_q    <= 1'b0;
    end else if (ce) begin
      rts_n_q      <= rts_n_d;
      dtr_n_q      <= dtr_n_d;
      ir_q         <= feature_control_reg_q[`UEFC_FEATURE_CONTROL_REG_IRINV] ? !ir_s : ir_s;
      halt_q       <= halt_d;
      tx_int_q     <= rs485 ? tsr_empty : thr_empty;
      tx_trg_int_q <= tx_fifo_level_count_q < tx_fifo_trigger_level_q;
      rx_trg_int_q <= rx_fifo_level_count_q >= rx_fifo_trigger_level_q;
      tx_busy_q    <= tx_busy_d;
      rx_full_q    <= rx_full_d;
    end
  end

  // Receive side character handling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_q       <= 1'b0;
      stop_det_q    <= 1'b0;
      special_q     <= 1'b0;
      stop_seen_q   <= 1'b0;
      res_seen_q    <= 1'b0;
      remote_stop_q <= 1'b0;
    end else if (ce) begin
      store_q    <= store_d;
      stop_det_q <= stop_hit;
      special_q  <= spec_hit;
      if (rx_valid) begin
        stop_seen_q <= seq && m_s1;
        res_seen_q  <= seq && m_r1;
      end
      // Disabling receive flow releases a held transmitter
      if (rx_mode == `UEFC_FLOW_NONE) begin
        remote_stop_q <= 1'b0;
      end else if (stop_hit) begin
        remote_stop_q <= 1'b1;
      end else if (res_hit) begin
        remote_stop_q <= 1'b0;
      end
    end
  end

  // Transmit flow character sender
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_q       <= uefc_pkg::UEFC_IDLE;
      send_stop_q  <= 1'b0;
      sent_stop_q  <= 1'b0;
      ctrl_char_q  <= `UEFC_RST_BYTE;
      ctrl_valid_q <= 1'b0;
    end else if (ce) begin
      send_q <= send_d;
      if (send_q == uefc_pkg::UEFC_IDLE && send_d == uefc_pkg::UEFC_CHAR1) begin
        send_stop_q  <= need_stop;
        sent_stop_q  <= need_stop;
        ctrl_char_q  <= (need_stop ? (tx_mode == `UEFC_FLOW_P2 ? stop2_q : stop1_q) :
                                     (tx_mode == `UEFC_FLOW_P2 ? res2_q : res1_q));
        ctrl_valid_q <= 1'b1;
      end else if (take && send_d == uefc_pkg::UEFC_CHAR2) begin
        ctrl_char_q  <= char_p2;
      end else if (take) begin
        ctrl_valid_q <= 1'b0;
        ctrl_char_q  <= char_p1;
      end
      if (tx_mode == `UEFC_FLOW_NONE && send_q == uefc_pkg::UEFC_IDLE) begin
        sent_stop_q <= 1'b0;
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign rts_n       = rts_n_q;
  assign dtr_n       = dtr_n_q;
  assign ir_rx_data  = ir_q;
  assign tx_halt     = halt_q;
  assign tx_int      = tx_int_q;
  assign tx_trig_int = tx_trg_int_q;
  assign rx_trig_int = rx_trg_int_q;
  assign rx_store    = store_q;
  assign stop_det    = stop_det_q;
  assign special_det = special_q;
  assign ctrl_char   = ctrl_char_q;
  assign ctrl_valid  = ctrl_valid_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_txint;
    ce && !rs485 |=> tx_int == $past(thr_empty);
  endproperty
  a_txint: assert property (p_txint) else $error("tx int not from holding");
  property p_rs485;
    ce && rs485 && tx_load |=> rts_n;
  endproperty
  a_rs485: assert property (p_rs485) else $error("rts not high after load");
  property p_tsrint;
    ce && rs485 |=> tx_int == $past(tsr_empty);
  endproperty
  a_tsrint: assert property (p_tsrint) else $error("tx int not from shift");
  property p_ir;
    ce && feature_control_reg_q[`UEFC_FEATURE_CONTROL_REG_IRINV] |=> ir_rx_data == !$past(ir_s);
  endproperty
  a_ir: assert property (p_ir) else $error("ir polarity wrong");
  property p_halt;
    ce && efr_q[`UEFC_EFR_ACTS] && (sel_dtr ? dsr_s : cts_s) |=> tx_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("selected pin high did not halt");
  property p_gpo;
    ce && !auto_rx && !rs485 |=> rts_n == !$past(mcr_q[`UEFC_MCR_RTS]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("rts not software bit");
  property p_gate;
    ce && wr_fire && s_mcr && !enh_wr |=>
      (mcr_q & `UEFC_MCR_ENH) == ($past(mcr_q) & `UEFC_MCR_ENH);
  endproperty
  a_gate: assert property (p_gate) else $error("gated bits changed");
  property p_cnt;
    rx_fifo_level_count_q <= DEPTH && tx_fifo_level_count_q <= DEPTH;
  endproperty
  a_cnt: assert property (p_cnt) else $error("fill count above depth");
  property p_nostore;
    ce && stop_hit |=> !rx_store && stop_det;
  endproperty
  a_nostore: assert property (p_nostore) else $error("stop char stored");

endmodule // uefc_top
`default_nettype wire
